// ==== logic/ccc_cfg.svh ====
// Constants of the codec core clock controller: register indexes, field positions,
// reset values, write masks and timing counts.
// Assumes it is included by its bare name from the design module.
`ifndef CCC_CFG_SVH
`define CCC_CFG_SVH

// Register indexes; the byte address is four times the index.
`define CCC_IDX_ADC_OSR 12'h00a
`define CCC_IDX_PREDIV 12'h014
`define CCC_IDX_RATES 12'h015
`define CCC_IDX_SYSCTL 12'h016
`define CCC_IDX_AIF1 12'h019
`define CCC_IDX_AIF2 12'h01a
`define CCC_IDX_AIF3 12'h01b
`define CCC_IDX_DAC_OSR 12'h021
`define CCC_IDX_FLL_REF 12'h070
`define CCC_IDX_STATUS 12'h080

// Reset values.
`define CCC_RST_ADC_OSR 16'h0001
`define CCC_RST_PREDIV 16'h0000
`define CCC_RST_RATES 16'h0c05
`define CCC_RST_SYSCTL 16'h0000
`define CCC_RST_AIF1 16'h0000
`define CCC_RST_AIF2 16'h0004
`define CCC_RST_AIF3 16'h0040
`define CCC_RST_DAC_OSR 16'h0000
`define CCC_RST_FLL_REF 16'h0000

// Writable bits of each register; all others read as zero.
`define CCC_MSK_ADC_OSR 16'h0001
`define CCC_MSK_PREDIV 16'h6001
`define CCC_MSK_RATES 16'h3c07
`define CCC_MSK_SYSCTL 16'hd00f
`define CCC_MSK_AIF1 16'h0040
`define CCC_MSK_AIF2 16'h0f1f
`define CCC_MSK_AIF3 16'h0fff
`define CCC_MSK_DAC_OSR 16'h0040
`define CCC_MSK_FLL_REF 16'h0003

// Field positions.
`define CCC_BIT_PREDIVIDE 0
`define CCC_BIT_TIMES_FOUR 13
`define CCC_BIT_DIV_SIXTEEN 14
`define CCC_BIT_INVERT 15
`define CCC_BIT_SOURCE 14
`define CCC_BIT_HALF_SEL 12
`define CCC_BIT_GPIO_ENA 3
`define CCC_BIT_CORE_ENA 2
`define CCC_BIT_DSP_ENA 1
`define CCC_BIT_SLOW_ENA 0
`define CCC_BIT_BCLK_OUT 6
`define CCC_BIT_FRAME_OUT 11
`define CCC_BIT_ADC_OSR 0
`define CCC_BIT_DAC_OSR 6

// Timing: master clock counts as lost after this time without a level change.
`define CCC_PCLK_MHZ 200
`define CCC_MCLK_LOSS_NS 1000
`define CCC_MCLK_LOSS_CYC ((`CCC_MCLK_LOSS_NS * `CCC_PCLK_MHZ) / 1000)
// Slow timeout clock half period, in 256kHz ticks, before its rate settings.
`define CCC_SLOW_BASE_TICKS 16'd64
`define CCC_MIN_FRAME_RATE 11'd8

`endif

// ==== logic/ccc_clock_control.sv ====
// Core clock selection, gating and derived clocks of the codec, with APB registers.
// Assumes all clock pins are sampled as levels by pclk, which must run well above them.
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ccc_cfg.svh"

module ccc_clock_control
   import ccc_pkg::*;
(
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Clock sources.
   input wire logic master_clock_in,
   input wire logic fll_clock_in,
   // Audio interface clock pins.
   input wire logic bit_clock_in,
   output logic bit_clock_out,
   output logic bit_clock_oe_n,
   input wire logic frame_clock_in,
   output logic frame_clock_out,
   output logic frame_clock_oe_n,
   // Derived clocks and strobes.
   output logic core_clock,
   output logic adc_clock_tick,
   output logic dac_clock_tick,
   output logic dsp_sample_tick,
   output logic int_256k_clock,
   output logic gpio_output_clock,
   output logic slow_timeout_clock,
   output logic fll_reference
);

   // ----------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------
   localparam logic [11:0] A_ADC_OSR = `CCC_IDX_ADC_OSR << 2;
   localparam logic [11:0] A_PREDIV = `CCC_IDX_PREDIV << 2;
   localparam logic [11:0] A_RATES = `CCC_IDX_RATES << 2;
   localparam logic [11:0] A_SYSCTL = `CCC_IDX_SYSCTL << 2;
   localparam logic [11:0] A_AIF1 = `CCC_IDX_AIF1 << 2;
   localparam logic [11:0] A_AIF2 = `CCC_IDX_AIF2 << 2;
   localparam logic [11:0] A_AIF3 = `CCC_IDX_AIF3 << 2;
   localparam logic [11:0] A_DAC_OSR = `CCC_IDX_DAC_OSR << 2;
   localparam logic [11:0] A_FLL_REF = `CCC_IDX_FLL_REF << 2;
   localparam logic [11:0] A_STATUS = `CCC_IDX_STATUS << 2;
   localparam logic [7:0] LOSS_CYC = 8'(`CCC_MCLK_LOSS_CYC);

   logic [15:0] adc_osr_reg, prediv_reg, rates_reg, sysctl_reg;
   logic [15:0] aif1_reg, aif2_reg, aif3_reg, dac_osr_reg, fll_ref_reg;
   logic [15:0] rd;
   logic hit, access_ok, acc_ok, master_present;
   ccc_gate_t gate_state;

   wire logic core_clock_enable = sysctl_reg[`CCC_BIT_CORE_ENA];
   wire logic core_clock_source_sel = sysctl_reg[`CCC_BIT_SOURCE];
   wire logic master_clock_invert = sysctl_reg[`CCC_BIT_INVERT];
   wire logic core_clock_predivide = prediv_reg[`CCC_BIT_PREDIVIDE];
   wire logic wr_fire = psel && penable && pready && pwrite && acc_ok;

   always_comb begin
      hit = 1'b1;
      rd = 16'h0000;
      case (paddr)
         A_ADC_OSR: rd = adc_osr_reg;
         A_PREDIV: rd = prediv_reg;
         A_RATES: rd = rates_reg;
         A_SYSCTL: rd = sysctl_reg;
         A_AIF1: rd = aif1_reg;
         A_AIF2: rd = aif2_reg;
         A_AIF3: rd = aif3_reg;
         A_DAC_OSR: rd = dac_osr_reg;
         A_FLL_REF: rd = fll_ref_reg;
         A_STATUS: rd = {14'h0000, master_present, gate_state == CCC_GATE_ON};
         default: hit = 1'b0;
      endcase
      access_ok = hit && (paddr == A_SYSCTL || !core_clock_enable || master_present);
   end

   // The answer is decided in the setup cycle, so every access has zero wait states.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
         acc_ok <= 1'b0;
      end else if (psel && !penable) begin
         pready <= 1'b1;
         pslverr <= !access_ok;
         acc_ok <= access_ok;
         prdata <= (access_ok && !pwrite) ? {16'h0000, rd} : 32'h0000_0000;
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         acc_ok <= 1'b0;
         prdata <= 32'h0000_0000;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         adc_osr_reg <= `CCC_RST_ADC_OSR;
         prediv_reg <= `CCC_RST_PREDIV;
         rates_reg <= `CCC_RST_RATES;
         sysctl_reg <= `CCC_RST_SYSCTL;
         aif1_reg <= `CCC_RST_AIF1;
         aif2_reg <= `CCC_RST_AIF2;
         aif3_reg <= `CCC_RST_AIF3;
         dac_osr_reg <= `CCC_RST_DAC_OSR;
         fll_ref_reg <= `CCC_RST_FLL_REF;
      end else if (wr_fire) begin
         case (paddr)
            A_ADC_OSR: adc_osr_reg <= pwdata[15:0] & `CCC_MSK_ADC_OSR;
            A_PREDIV: prediv_reg <= pwdata[15:0] & `CCC_MSK_PREDIV;
            A_RATES: rates_reg <= pwdata[15:0] & `CCC_MSK_RATES;
            A_SYSCTL: sysctl_reg <= pwdata[15:0] & `CCC_MSK_SYSCTL;
            A_AIF1: aif1_reg <= pwdata[15:0] & `CCC_MSK_AIF1;
            A_AIF2: aif2_reg <= pwdata[15:0] & `CCC_MSK_AIF2;
            A_AIF3: aif3_reg <= pwdata[15:0] & `CCC_MSK_AIF3;
            A_DAC_OSR: dac_osr_reg <= pwdata[15:0] & `CCC_MSK_DAC_OSR;
            A_FLL_REF: fll_ref_reg <= pwdata[15:0] & `CCC_MSK_FLL_REF;
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Master clock presence
   // ----------------------------------------------------------------
   logic mc_q, mc_prev;
   logic [7:0] loss_cnt;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mc_q <= 1'b0;
         mc_prev <= 1'b0;
         loss_cnt <= 8'h00;
         master_present <= 1'b0;
      end else begin
         mc_q <= master_clock_in;
         mc_prev <= mc_q;
         if (mc_q != mc_prev) begin
            loss_cnt <= 8'h00;
            master_present <= 1'b1;
         end else if (loss_cnt >= LOSS_CYC) begin
            master_present <= 1'b0;
         end else begin
            loss_cnt <= loss_cnt + 8'h01;
         end
      end
   end

   // ----------------------------------------------------------------
   // Core clock source, predivide and gate
   // ----------------------------------------------------------------
   logic src_q, src_prev, half_q, core_prev;
   wire logic src_raw = core_clock_source_sel ? fll_clock_in : (master_clock_in ^ master_clock_invert);
   wire logic pre = core_clock_predivide ? half_q : src_q;
   wire logic core_rise = core_clock && !core_prev;
   wire logic core_fall = !core_clock && core_prev;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_q <= 1'b0;
         src_prev <= 1'b0;
         half_q <= 1'b0;
      end else begin
         src_q <= src_raw;
         src_prev <= src_q;
         if (src_q && !src_prev) begin
            half_q <= !half_q;
         end
      end
   end

   // The gate only changes while the source is low, so no shortened high phase leaks out.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gate_state <= CCC_GATE_OFF;
         core_clock <= 1'b0;
         core_prev <= 1'b0;
      end else begin
         case (gate_state)
            CCC_GATE_OFF: if (core_clock_enable && !pre) gate_state <= CCC_GATE_ON;
            CCC_GATE_ON: if (!core_clock_enable && !pre) gate_state <= CCC_GATE_OFF;
            default: gate_state <= CCC_GATE_OFF;
         endcase
         core_clock <= pre && (gate_state == CCC_GATE_ON);
         core_prev <= core_clock;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fll_reference <= 1'b0;
      end else begin
         case (fll_ref_reg[1:0])
            2'h1: fll_reference <= bit_clock_in;
            2'h2: fll_reference <= frame_clock_in;
            default: fll_reference <= master_clock_in;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Automatic converter, DSP and 256kHz dividers
   // ----------------------------------------------------------------
   function automatic logic [10:0] ratio_of(input logic [3:0] code);
      case (code)
         4'h0: ratio_of = 11'd64;
         4'h1: ratio_of = 11'd128;
         4'h2: ratio_of = 11'd192;
         4'h3: ratio_of = 11'd256;
         4'h4: ratio_of = 11'd384;
         4'h5: ratio_of = 11'd512;
         4'h6: ratio_of = 11'd768;
         4'h7: ratio_of = 11'd1024;
         4'h8: ratio_of = 11'd1408;
         default: ratio_of = 11'd1536;
      endcase
   endfunction : ratio_of

   function automatic logic [5:0] fs_khz(input logic [2:0] code);
      case (code)
         3'h0: fs_khz = 6'd8;
         3'h1: fs_khz = 6'd12;
         3'h2: fs_khz = 6'd16;
         3'h3: fs_khz = 6'd24;
         3'h4: fs_khz = 6'd32;
         default: fs_khz = 6'd48;
      endcase
   endfunction : fs_khz

   // Oversampling in both converters follows from the ratio: ratio/64 or ratio/128 edges.
   logic [10:0] ratio, adc_div, dac_div, adc_cnt, dac_cnt, fs_cnt, k_div, k_cnt;
   logic [16:0] k_prod;
   always_comb begin
      ratio = ratio_of(rates_reg[13:10]);
      adc_div = adc_osr_reg[`CCC_BIT_ADC_OSR] ? (ratio >> 7) : (ratio >> 6);
      dac_div = dac_osr_reg[`CCC_BIT_DAC_OSR] ? (ratio >> 7) : (ratio >> 6);
      if (adc_div == 11'd0) adc_div = 11'd1;
      if (dac_div == 11'd0) dac_div = 11'd1;
      k_prod = 17'(ratio * fs_khz(rates_reg[2:0]));
      k_div = 11'(k_prod >> 9);
      if (k_div == 11'd0) k_div = 11'd1;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         adc_cnt <= 11'd0;
         dac_cnt <= 11'd0;
         fs_cnt <= 11'd0;
         adc_clock_tick <= 1'b0;
         dac_clock_tick <= 1'b0;
         dsp_sample_tick <= 1'b0;
      end else begin
         adc_clock_tick <= core_rise && (adc_cnt + 11'd1 >= adc_div);
         dac_clock_tick <= core_rise && (dac_cnt + 11'd1 >= dac_div);
         dsp_sample_tick <= core_rise && sysctl_reg[`CCC_BIT_DSP_ENA] && (fs_cnt + 11'd1 >= ratio);
         if (core_rise) begin
            adc_cnt <= (adc_cnt + 11'd1 >= adc_div) ? 11'd0 : adc_cnt + 11'd1;
            dac_cnt <= (dac_cnt + 11'd1 >= dac_div) ? 11'd0 : dac_cnt + 11'd1;
            fs_cnt <= (fs_cnt + 11'd1 >= ratio) ? 11'd0 : fs_cnt + 11'd1;
         end
      end
   end

   // 256kHz clock, toggled every half period of core edges
   logic k_tick;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         k_cnt <= 11'd0;
         int_256k_clock <= 1'b0;
         k_tick <= 1'b0;
      end else begin
         k_tick <= 1'b0;
         if (core_rise) begin
            if (k_cnt + 11'd1 >= k_div) begin
               k_cnt <= 11'd0;
               int_256k_clock <= !int_256k_clock;
               k_tick <= !int_256k_clock;
            end else begin
               k_cnt <= k_cnt + 11'd1;
            end
         end
      end
   end

   logic [15:0] slow_half, slow_cnt;
   always_comb begin
      slow_half = `CCC_SLOW_BASE_TICKS;
      if (!sysctl_reg[`CCC_BIT_HALF_SEL]) slow_half = slow_half << 1;
      if (prediv_reg[`CCC_BIT_TIMES_FOUR]) slow_half = slow_half >> 2;
      if (prediv_reg[`CCC_BIT_DIV_SIXTEEN]) slow_half = slow_half << 4;
      if (slow_half == 16'd0) slow_half = 16'd1;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slow_cnt <= 16'd0;
         slow_timeout_clock <= 1'b0;
      end else if (!sysctl_reg[`CCC_BIT_SLOW_ENA]) begin
         slow_cnt <= 16'd0;
         slow_timeout_clock <= 1'b0;
      end else if (k_tick) begin
         if (slow_cnt + 16'd1 >= slow_half) begin
            slow_cnt <= 16'd0;
            slow_timeout_clock <= !slow_timeout_clock;
         end else begin
            slow_cnt <= slow_cnt + 16'd1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Bit clock and GPIO clock dividers
   // ----------------------------------------------------------------
   // Periods are counted in core clock edges so the 1.5 and 5.5 ratios stay exact.
   logic [6:0] div_p [2];
   logic [6:0] div_cnt [2];
   logic div_lvl [2];
   logic div_run [2];

   always_comb begin
      case (aif2_reg[4:0])
         5'h00: div_p[0] = 7'd2;
         5'h01: div_p[0] = 7'd3;
         5'h02: div_p[0] = 7'd4;
         5'h03: div_p[0] = 7'd6;
         5'h04: div_p[0] = 7'd8;
         5'h05: div_p[0] = 7'd10;
         5'h06: div_p[0] = 7'd11;
         5'h07: div_p[0] = 7'd12;
         5'h08: div_p[0] = 7'd16;
         5'h09: div_p[0] = 7'd20;
         5'h0a: div_p[0] = 7'd22;
         5'h0b: div_p[0] = 7'd24;
         5'h0c: div_p[0] = 7'd32;
         5'h0d: div_p[0] = 7'd40;
         5'h0e: div_p[0] = 7'd44;
         5'h0f: div_p[0] = 7'd48;
         5'h10: div_p[0] = 7'd50;
         5'h11: div_p[0] = 7'd60;
         5'h12: div_p[0] = 7'd64;
         5'h13: div_p[0] = 7'd88;
         default: div_p[0] = 7'd96;
      endcase
      case (aif2_reg[11:8])
         4'h1: div_p[1] = 7'd4;
         4'h2: div_p[1] = 7'd6;
         4'h3: div_p[1] = 7'd8;
         4'h4: div_p[1] = 7'd11;
         4'h5: div_p[1] = 7'd12;
         4'h6: div_p[1] = 7'd16;
         4'h7: div_p[1] = 7'd24;
         4'h8: div_p[1] = 7'd32;
         default: div_p[1] = 7'd2;
      endcase
      div_run[0] = aif1_reg[`CCC_BIT_BCLK_OUT];
      div_run[1] = sysctl_reg[`CCC_BIT_GPIO_ENA];
   end

   for (genvar g = 0; g < 2; g++) begin : g_div
      logic [6:0] nxt;
      assign nxt = (div_cnt[g] + 7'd1 >= div_p[g]) ? 7'd0 : div_cnt[g] + 7'd1;
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            div_cnt[g] <= 7'd0;
            div_lvl[g] <= 1'b0;
         end else if (!div_run[g]) begin
            div_cnt[g] <= 7'd0;
            div_lvl[g] <= 1'b0;
         end else if (core_rise || core_fall) begin
            div_cnt[g] <= nxt;
            div_lvl[g] <= nxt < (div_p[g] >> 1);
         end
      end
   end

   // ----------------------------------------------------------------
   // Frame clock and pin drivers
   // ----------------------------------------------------------------
   logic bit_src_prev;
   logic [10:0] fr_cnt, fr_rate;
   wire logic frame_master = aif3_reg[`CCC_BIT_FRAME_OUT];
   wire logic bit_src = div_run[0] ? div_lvl[0] : bit_clock_in;
   // frame rate, clamped to the legal floor
   assign fr_rate = (aif3_reg[10:0] < `CCC_MIN_FRAME_RATE) ? `CCC_MIN_FRAME_RATE : aif3_reg[10:0];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bit_src_prev <= 1'b0;
         fr_cnt <= 11'd0;
         frame_clock_out <= 1'b0;
         frame_clock_oe_n <= 1'b1;
         bit_clock_out <= 1'b0;
         bit_clock_oe_n <= 1'b1;
         gpio_output_clock <= 1'b0;
      end else begin
         bit_src_prev <= bit_src;
         bit_clock_out <= div_lvl[0];
         bit_clock_oe_n <= !div_run[0];
         gpio_output_clock <= div_lvl[1];
         frame_clock_oe_n <= !frame_master;
         if (!frame_master) begin
            fr_cnt <= 11'd0;
            frame_clock_out <= 1'b0;
         end else if (!bit_src && bit_src_prev) begin
            fr_cnt <= (fr_cnt + 11'd1 >= fr_rate) ? 11'd0 : fr_cnt + 11'd1;
            frame_clock_out <= fr_cnt + 11'd1 < (fr_rate >> 1);
         end
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_steady;
      ($stable(sysctl_reg) && $stable(prediv_reg) && gate_state == CCC_GATE_ON) [*3];
   endsequence

   a_gate_no_runt: assert property ($rose(core_clock) |-> gate_state == CCC_GATE_ON)
      else $error("core clock rose while gate off");
   a_gate_stops: assert property (gate_state == CCC_GATE_OFF && $past(gate_state) == CCC_GATE_OFF |-> !core_clock)
      else $error("core clock running while disabled");
   a_master_path: assert property (s_steady ##0 (!core_clock_predivide && !core_clock_source_sel)
      |-> core_clock == $past(master_clock_in ^ master_clock_invert, 2))
      else $error("core clock does not follow master clock");
   a_loop_path: assert property (s_steady ##0 (!core_clock_predivide && core_clock_source_sel)
      |-> core_clock == $past(fll_clock_in, 2))
      else $error("core clock does not follow loop clock");
   a_half_rate: assert property (s_steady ##0 core_clock_predivide
      |-> !$rose(core_clock) || $past(src_q && !src_prev, 2))
      else $error("divided core clock rose off its source edge");
   a_reg_blocked: assert property (psel && !penable && paddr != A_SYSCTL && core_clock_enable && !master_present
      |=> pready && pslverr)
      else $error("access allowed without master clock");
   a_sysctl_open: assert property (psel && !penable && paddr == A_SYSCTL |=> pready && !pslverr)
      else $error("system clock control register refused");
   a_tick_edge: assert property (adc_clock_tick || dac_clock_tick |-> $past(core_rise))
      else $error("converter tick without core edge");
   a_bit_div_range: assert property ($past(core_rise || core_fall) && $stable(aif2_reg)
      |-> div_cnt[0] < div_p[0])
      else $error("bit clock count out of range");
   a_frame_range: assert property ($past(frame_master && !bit_src && bit_src_prev)
      && $stable(aif3_reg) |-> fr_cnt < fr_rate)
      else $error("frame count out of range");

endmodule : ccc_clock_control
`default_nettype wire

// ==== logic/ccc_pkg.sv ====
// Types of the codec core clock controller.
// Assumes it is compiled before the design module and the bench, which import it.
`default_nettype none
package ccc_pkg;
   typedef enum logic [1:0] {
      CCC_GATE_OFF = 2'b01,
      CCC_GATE_ON = 2'b10
   } ccc_gate_t;
endpackage : ccc_pkg
`default_nettype wire

// ==== verif/ccc_clock_source.sv ====
// Model of the master clock source and the locked loop output that feed the clock block.
// Assumes pclk is the bench clock; each clock stands low while its run input is low.
`timescale 1ns/1ps
`default_nettype none
module ccc_clock_source #(
   parameter int MHALF = 4,
   parameter int FHALF = 2
) (
   // Bench clock and run controls.
   input wire logic pclk,
   input wire logic mrun,
   input wire logic frun,
   // Clock outputs.
   output logic master_clock_in = 1'b0,
   output logic fll_clock_in = 1'b0
);
   int mc = 0;
   int fc = 0;
   // a 25MHz master clock keeps the core clock above both floors.
   // no mono mode is modelled, so the stereo ratios apply.
   // reference clocks run
   // Stopped clocks park low so that no stale edge reaches the block.
   always @(posedge pclk) begin
      mc <= (mc + 1) % MHALF;
      fc <= (fc + 1) % FHALF;
      if (!mrun) master_clock_in <= 1'b0;
      else if (mc == 0) master_clock_in <= !master_clock_in;
      if (!frun) fll_clock_in <= 1'b0;
      else if (fc == 0) fll_clock_in <= !fll_clock_in;
   end
endmodule : ccc_clock_source
`default_nettype wire

// ==== verif/codec_system_clock_control_test.sv ====
// Self-checking bench of the codec clock block: APB register tests and core clock counts.
// Assumes the design answers each APB transfer and the clock model above drives its sources.
`timescale 1ns/1ps
`default_nettype none
module codec_system_clock_control_test
   import ccc_pkg::*;
;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, mrun = 0, frun = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic pready, pslverr, er, mck, fck, core_clock, cc_q = 0;
   logic bco, boe, fco, foe, gco, adt, dat, bq = 0, fq = 0, gq = 0;
   int num_errors = 0, checks = 0, cyc = 0, edges = 0;
   int bedges = 0, fedges = 0, gedges = 0, aticks = 0, dticks = 0;
   ccc_clock_source SRC (.pclk(pclk), .mrun(mrun), .frun(frun),
      .master_clock_in(mck), .fll_clock_in(fck));
   ccc_clock_control DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .master_clock_in(mck), .fll_clock_in(fck), .bit_clock_in(1'b0),
      .bit_clock_out(bco), .bit_clock_oe_n(boe), .frame_clock_in(1'b0),
      .frame_clock_out(fco), .frame_clock_oe_n(foe), .core_clock(core_clock),
      .adc_clock_tick(adt), .dac_clock_tick(dat), .dsp_sample_tick(), .int_256k_clock(),
      .gpio_output_clock(gco), .slow_timeout_clock(), .fll_reference());
   initial forever #2.5 pclk = !pclk;
   always @(posedge pclk) begin
      if (core_clock === 1'b1 && cc_q === 1'b0) edges++;
      if (bco === 1'b1 && bq === 1'b0) bedges++;
      if (fco === 1'b1 && fq === 1'b0) fedges++;
      if (gco === 1'b1 && gq === 1'b0) gedges++;
      if (adt === 1'b1) aticks++;
      if (dat === 1'b1) dticks++;
      cc_q = core_clock;
      bq = bco;
      fq = fco;
      gq = gco;
      cyc++;
      if (cyc == 5000) begin
         num_errors++;
         complete_run();
      end
   end
   task complete_run();
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : complete_run
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // The request stays put until pready is sampled high at a rising edge.
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Counts core clock rising edges over 160 cycles against the window from lo to hi.
   task edge_chk(input int lo, input int hi);
      edges = 0;
      bedges = 0;
      fedges = 0;
      gedges = 0;
      aticks = 0;
      dticks = 0;
      repeat (160) @(posedge pclk);
      chk("core edges", {31'h0, edges >= lo && edges <= hi}, 32'h1);
   endtask : edge_chk
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      // first reads run with the enable clear
      apb(0, 12'h054, 0);
      chk("rates", rd, 32'h0c05); // reset codes
      apb(0, 12'h068, 0);
      chk("aif2", rd, 32'h0004); // default divider
      apb(0, 12'h3fc, 0);
      chk("unmapped err", {31'h0, er}, 32'h1);
      $display("test reset values done");
      apb(1, 12'h058, 32'h0004);
      repeat (250) @(posedge pclk);
      apb(0, 12'h054, 0);
      chk("blocked err", {31'h0, er}, 32'h1);
      apb(0, 12'h058, 0);
      chk("sysctl open", {er, rd[30:0]}, 32'h0004);
      mrun <= 1'b1;
      repeat (50) @(posedge pclk);
      apb(0, 12'h054, 0);
      chk("unblocked err", {31'h0, er}, 32'h0);
      edge_chk(19, 21);
      $display("test access gating done");
      // enable dropped before the source changes
      apb(1, 12'h058, 32'h0000);
      repeat (20) @(posedge pclk);
      edge_chk(0, 0);
      apb(1, 12'h058, 32'h8000);
      apb(1, 12'h058, 32'h8004);
      edge_chk(19, 21);
      apb(1, 12'h058, 32'h8000);
      repeat (20) @(posedge pclk);
      apb(1, 12'h050, 32'h0001);
      apb(1, 12'h058, 32'h8004);
      edge_chk(9, 11);
      apb(1, 12'h058, 32'h8000);
      repeat (20) @(posedge pclk);
      frun <= 1'b1;
      apb(1, 12'h058, 32'h4000);
      apb(1, 12'h058, 32'h4004);
      edge_chk(19, 21);
      $display("test source and divide done");
      // host sets up the derived clocks itself
      // all clock set-up is done before any playback
      apb(1, 12'h064, 32'h0040);
      apb(1, 12'h068, 32'h0300);
      apb(1, 12'h06c, 32'h0808);
      apb(1, 12'h058, 32'h400c);
      edge_chk(19, 21);
      chk("bit edges", {31'h0, bedges >= 19 && bedges <= 21}, 32'h1);
      chk("gpio edges", {31'h0, gedges >= 4 && gedges <= 6}, 32'h1);
      chk("frame edges", {31'h0, fedges >= 2 && fedges <= 3}, 32'h1);
      chk("adc ticks", {31'h0, aticks >= 9 && aticks <= 11}, 32'h1);
      chk("dac ticks", {31'h0, dticks >= 4 && dticks <= 6}, 32'h1);
      chk("pin enables", {30'h0, boe, foe}, 32'h0);
      $display("test derived clocks done");
      complete_run();
   end
endmodule : codec_system_clock_control_test
`default_nettype wire
